// >>> lpt_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LPT_OFF_PANEL_TYPE   8'h10
`define LPT_OFF_HTOTAL       8'h12
`define LPT_OFF_HDISP_WIDTH  8'h14
`define LPT_OFF_HDSTART_LO   8'h16
`define LPT_OFF_HDSTART_HI   8'h17
`define LPT_OFF_VTOTAL_LO    8'h18
`define LPT_OFF_VTOTAL_HI    8'h19
`define LPT_OFF_VHEIGHT_LO   8'h1c
`define LPT_OFF_VHEIGHT_HI   8'h1d
`define LPT_OFF_VDSTART_LO   8'h1e
`define LPT_OFF_VDSTART_HI   8'h1f
`define LPT_OFF_LINE_WPOL    8'h20
`define LPT_OFF_LSTART_LO    8'h22
`define LPT_OFF_LSTART_HI    8'h23
`define LPT_OFF_FRAME_WPOL   8'h24
`define LPT_OFF_FSTART_LO    8'h26
`define LPT_OFF_FSTART_HI    8'h27
`define LPT_OFF_STAT_LINE_LO 8'h28
`define LPT_OFF_STAT_LINE_HI 8'h29

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define LPT_REG_COUNT        17
`define LPT_REG_RESET        8'h00
`define LPT_PTYPE_ACTIVE     2'b01
`define LPT_FMT_LSB          4
`define LPT_POL_BIT          7

// ****************************************************************
// Timing counts, in pixel periods
// ****************************************************************
`define LPT_DISPLAY_START_ACTIVE_ADD  11'd5
`define LPT_DISPLAY_START_PASSIVE_ADD 11'd22
`define LPT_SC_PERIOD_FMT1   3'd4
`define LPT_SC_PERIOD_FMT2   3'd2
`define LPT_SC_PERIOD_B16    3'd5

`endif

// >>> lpt_pkg.sv
// Types shared by the panel timing generator
package lpt_pkg;
    // Passive panel data format, panel_type_config bits 5-4
    typedef enum logic [1:0] {
        LPT_FMT1 = 2'b00,
        LPT_FMT2 = 2'b01,
        LPT_B16  = 2'b10,
        LPT_RSVD = 2'b11
    } lpt_fmt_e;

    // Pixel or line position
    typedef logic [10:0] lpt_pos_t;
endpackage

// >>> lpt_timing_gen.sv
// Panel timing generator: counters, pulses, shift clocks, data, registers
//
// How it works
// R01 - Format 1 drives two 4-period shift clocks
// R02 - Format 1 data changes between falling edges
// R03 - Format 1 last shift edges end window
// R04 - Format 1 first edges two after start
// R05 - Frame pulse changes only at line start
// R06 - Format 2 shift clock period is two
// R07 - Format 2 last fall one before end
// R08 - 16-bit shift period five, data centred
// R09 - AC bias flips at frame line start
// R10 - Horizontal total is field plus one, times 8
// R11 - Display width is field plus one, times 8
// R12 - Active display start is value plus five
// R13 - Line pulse start plus one, width plus one
// R14 - Vertical total and height are value plus one
// R15 - Frame and vertical starts used as is
// R16 - Frame pulse width is field plus one
// R17 - Software keeps active width sixteen or more
// R18 - Panel type 01 selects active matrix
// R19 - Bit 7 sets pulse polarity, 0 low
// R20 - Display enable opens at display start
// R21 - Display enable lasts the display width
// R22 - Active shift clock follows pixel clock
// R23 - Counters compared with programmed positions
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lpt_consts.svh"

module lpt_timing_gen #(
    parameter int DATA_W = 18                // Panel data width
) (
    input  wire logic              core_clk_in,      // 40 MHz core clock
    input  wire logic              resetn_in,        // Sync reset, low
    input  wire logic              clk_en_in,        // Freezes state when low
    input  wire logic              pixel_clk_in,     // Pixel clock pin
    input  wire logic [7:0]        addr_in,          // Register address
    input  wire logic [7:0]        wr_data_in,       // Register write data
    input  wire logic              wr_en_in,         // Write strobe
    input  wire logic              rd_en_in,         // Read strobe
    output logic      [7:0]        rd_data_out,      // Read data, next cycle
    input  wire logic [DATA_W-1:0] pixel_data_in,    // Next pixel word
    output logic                   pixel_take_out,   // Pixel word consumed
    output logic      [DATA_W-1:0] panel_data_out,   // Panel data pins
    output logic                   line_pulse_out,   // Line pulse pin
    output logic                   frame_pulse_out,  // Frame pulse pin
    output logic                   shift_clock_out,  // Shift clock pin
    output logic                   second_shift_clock_out, // Second shift
    output logic                   display_enable_out, // Display enable
    output logic                   ac_bias_out       // AC bias pin
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    // The 16-bit passive mode needs at least 16 data pins
    if (DATA_W < 16 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 16 and 32");
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] regs_q [0:`LPT_REG_COUNT-1]; // Programmed timing values
    logic [7:0] rd_data_q;                   // Read answer register

    // Maps an address onto a slot; bit 5 flags a hit
    function automatic logic [5:0] reg_slot(input logic [7:0] a);
        case (a)
            `LPT_OFF_PANEL_TYPE:  reg_slot = 6'h20;
            `LPT_OFF_HTOTAL:      reg_slot = 6'h21;
            `LPT_OFF_HDISP_WIDTH: reg_slot = 6'h22;
            `LPT_OFF_HDSTART_LO:  reg_slot = 6'h23;
            `LPT_OFF_HDSTART_HI:  reg_slot = 6'h24;
            `LPT_OFF_VTOTAL_LO:   reg_slot = 6'h25;
            `LPT_OFF_VTOTAL_HI:   reg_slot = 6'h26;
            `LPT_OFF_VHEIGHT_LO:  reg_slot = 6'h27;
            `LPT_OFF_VHEIGHT_HI:  reg_slot = 6'h28;
            `LPT_OFF_VDSTART_LO:  reg_slot = 6'h29;
            `LPT_OFF_VDSTART_HI:  reg_slot = 6'h2a;
            `LPT_OFF_LINE_WPOL:   reg_slot = 6'h2b;
            `LPT_OFF_LSTART_LO:   reg_slot = 6'h2c;
            `LPT_OFF_LSTART_HI:   reg_slot = 6'h2d;
            `LPT_OFF_FRAME_WPOL:  reg_slot = 6'h2e;
            `LPT_OFF_FSTART_LO:   reg_slot = 6'h2f;
            `LPT_OFF_FSTART_HI:   reg_slot = 6'h30;
            default:              reg_slot = 6'h00;
        endcase
    endfunction

    logic [5:0] wr_slot;  // Decoded write target
    logic [5:0] rd_slot;  // Decoded read target
    assign wr_slot = reg_slot(addr_in);
    assign rd_slot = reg_slot(addr_in);

    // Software writes; unmapped writes are dropped
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < `LPT_REG_COUNT; i++) begin
                regs_q[i] <= `LPT_REG_RESET;
            end
        end else if (clk_en_in && wr_en_in && wr_slot[5]) begin
            regs_q[wr_slot[4:0]] <= wr_data_in;
        end
    end

    // ****************************************************************
    // Decoded timing values
    // ****************************************************************
    logic           is_active;   // Active-matrix panel selected
    lpt_pkg::lpt_fmt_e fmt;      // Passive data format
    logic           line_pol;    // 1 gives active-high line pulse
    logic           frame_pol;   // 1 gives active-high frame pulse
    lpt_pkg::lpt_pos_t ht;       // Horizontal total, pixels
    lpt_pkg::lpt_pos_t display_width;      // Display width, pixels
    lpt_pkg::lpt_pos_t display_start;     // Display start, pixels
    lpt_pkg::lpt_pos_t line_start;      // Line pulse start, pixels
    lpt_pkg::lpt_pos_t line_pulse_width;      // Line pulse width, pixels
    lpt_pkg::lpt_pos_t vt;       // Vertical total, lines
    lpt_pkg::lpt_pos_t display_height;      // Display height, lines
    lpt_pkg::lpt_pos_t vertical_display_start;     // Vertical display start, lines
    lpt_pkg::lpt_pos_t frame_start;      // Frame pulse start, lines
    lpt_pkg::lpt_pos_t frame_pulse_width;      // Frame pulse width, lines

    assign is_active = regs_q[0][1:0] == `LPT_PTYPE_ACTIVE;           // [R18]
    assign fmt       = lpt_pkg::lpt_fmt_e'(regs_q[0][`LPT_FMT_LSB+:2]);
    assign line_pol  = regs_q[11][`LPT_POL_BIT];                      // [R19]
    assign frame_pol = regs_q[14][`LPT_POL_BIT];                      // [R19]
    assign ht   = {1'b0, regs_q[1][6:0], 3'b000} + 11'd8;             // [R10]
    assign display_width  = {1'b0, regs_q[2][6:0], 3'b000} + 11'd8;             // [R11]
    assign display_start = {1'b0, regs_q[4][1:0], regs_q[3]} +
                  (is_active ? `LPT_DISPLAY_START_ACTIVE_ADD
                             : `LPT_DISPLAY_START_PASSIVE_ADD);                // [R12]
    assign line_start  = {1'b0, regs_q[13][1:0], regs_q[12]} + 11'd1;        // [R13]
    assign line_pulse_width  = {4'b0, regs_q[11][6:0]} + 11'd1;                    // [R13]
    assign vt   = {1'b0, regs_q[6][1:0], regs_q[5]} + 11'd1;          // [R14]
    assign display_height  = {1'b0, regs_q[8][1:0], regs_q[7]} + 11'd1;          // [R14]
    assign vertical_display_start = {1'b0, regs_q[10][1:0], regs_q[9]};                 // [R15]
    assign frame_start  = {1'b0, regs_q[16][1:0], regs_q[15]};                // [R15]
    assign frame_pulse_width  = {8'b0, regs_q[14][2:0]} + 11'd1;                    // [R16]

    // ****************************************************************
    // Pixel clock sampling
    // ****************************************************************
    logic pix_s1_q;  // First sync stage, read only by the second
    logic pix_s2_q;  // Second sync stage
    logic pix_s3_q;  // Edge detect history
    logic tick;      // One core cycle per pixel period
    logic tick_en;   // Tick that really advances state

    // The pin is asynchronous to the core clock
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            pix_s1_q <= 1'b0;
            pix_s2_q <= 1'b0;
            pix_s3_q <= 1'b0;
        end else if (clk_en_in) begin
            pix_s1_q <= pixel_clk_in;
            pix_s2_q <= pix_s1_q;
            pix_s3_q <= pix_s2_q;
        end
    end

    assign tick    = pix_s2_q && !pix_s3_q;
    assign tick_en = tick && clk_en_in;

    // ****************************************************************
    // Position counters
    // ****************************************************************
    lpt_pkg::lpt_pos_t hcnt_q;  // Pixel within line
    lpt_pkg::lpt_pos_t vcnt_q;  // Line within frame
    lpt_pkg::lpt_pos_t hnext;   // Pixel after this tick
    lpt_pkg::lpt_pos_t vnext;   // Line after this tick
    logic              hwrap;   // Last pixel of the line

    // Wrap on >= so a shortened total never strands the counter
    assign hwrap = hcnt_q >= ht - 11'd1;                              // [R10]
    assign hnext = hwrap ? 11'd0 : hcnt_q + 11'd1;                    // [R23]
    assign vnext = !hwrap ? vcnt_q :
                   (vcnt_q >= vt - 11'd1) ? 11'd0 : vcnt_q + 11'd1;   // [R14]

    // Both counters move on the pixel tick only
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            hcnt_q <= 11'd0;
            vcnt_q <= 11'd0;
        end else if (tick_en) begin
            hcnt_q <= hnext;                                          // [R23]
            vcnt_q <= vnext;
        end
    end

    // ****************************************************************
    // Window decode on the next position
    // ****************************************************************
    logic       h_win;    // Inside horizontal display window
    logic       v_win;    // Inside vertical display window
    logic       win;      // Inside display area
    logic       line_act; // Line pulse asserted, before polarity
    logic       frm_act;  // Frame pulse asserted, before polarity
    logic [2:0] sc_per;   // Passive shift clock period
    logic [2:0] ph_q;     // Phase within shift clock period
    logic [2:0] ph_next;  // Phase after this tick

    // Twelve-bit sums so a large start never wraps the compare
    assign h_win = hnext >= display_start &&
                   {1'b0, hnext} < {1'b0, display_start} + {1'b0, display_width};        // [R21]
    assign v_win = vnext >= vertical_display_start &&
                   {1'b0, vnext} < {1'b0, vertical_display_start} + {1'b0, display_height};
    assign win   = h_win && v_win;
    assign line_act = hnext >= line_start &&
                      {1'b0, hnext} < {1'b0, line_start} + {1'b0, line_pulse_width};      // [R13]
    assign frm_act  = vnext >= frame_start &&
                      {1'b0, vnext} < {1'b0, frame_start} + {1'b0, frame_pulse_width};      // [R16]

    // Shift clock period per passive format
    always_comb begin
        case (fmt)
            lpt_pkg::LPT_FMT1: sc_per = `LPT_SC_PERIOD_FMT1;          // [R01]
            lpt_pkg::LPT_FMT2: sc_per = `LPT_SC_PERIOD_FMT2;          // [R06]
            lpt_pkg::LPT_B16:  sc_per = `LPT_SC_PERIOD_B16;           // [R08]
            default:           sc_per = `LPT_SC_PERIOD_FMT1;
        endcase
    end

    // Phase restarts at display start so edges line up per line
    assign ph_next = (hnext == display_start) ? 3'd0 :
                     (ph_q >= sc_per - 3'd1) ? 3'd0 : ph_q + 3'd1;    // [R04]

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            ph_q <= 3'd0;
        end else if (tick_en) begin
            ph_q <= ph_next;
        end
    end

    // ****************************************************************
    // Shift clocks and data strobe
    // ****************************************************************
    logic sc_d;    // Next primary shift clock level
    logic sc2_d;   // Next second shift clock level
    logic upd;     // Fetch a new pixel word this tick
    logic sc_q;    // Primary shift clock register
    logic sc2_q;   // Second shift clock register

    always_comb begin
        sc_d  = 1'b0;
        sc2_d = 1'b0;
        upd   = 1'b0;
        if (is_active) begin
            upd = win;                     // One word per pixel
        end else if (win) begin
            case (fmt)
                lpt_pkg::LPT_FMT1: begin
                    // Second clock is the primary shifted two pixels
                    sc_d  = ph_next >= 3'd2;                          // [R03]
                    sc2_d = ph_next < 3'd2;                           // [R01]
                    upd   = ph_next[0];                               // [R02]
                end
                lpt_pkg::LPT_FMT2: begin
                    // Last fall lands one pixel before window end
                    sc_d = ph_next == 3'd0;                           // [R07]
                    upd  = ph_next == 3'd0;                           // [R06]
                end
                lpt_pkg::LPT_B16: begin
                    // High two, low three; data two before the rise
                    sc_d = ph_next == 3'd2 || ph_next == 3'd3;        // [R08]
                    upd  = ph_next == 3'd0;                           // [R08]
                end
                default: begin
                    sc_d = 1'b0;
                end
            endcase
        end
    end

    assign pixel_take_out = tick_en && upd;

    // Active panels copy the pixel clock; passive ones step on ticks
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            sc_q  <= 1'b0;
            sc2_q <= 1'b0;
        end else if (clk_en_in) begin
            if (is_active) begin
                sc_q  <= pix_s2_q;                                    // [R22]
                sc2_q <= 1'b0;
            end else if (tick) begin
                sc_q  <= sc_d;
                sc2_q <= sc2_d;
            end
        end
    end

    // ****************************************************************
    // Panel data and display enable
    // ****************************************************************
    logic [DATA_W-1:0] data_q;  // Panel data register
    logic              de_q;    // Display enable register

    // Data changes a half pixel before the active falling edge
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            data_q <= '0;
            de_q   <= 1'b0;
        end else if (tick_en) begin
            if (upd) begin
                data_q <= pixel_data_in;                              // [R22]
            end
            // Opens only at display start, so a mid-line switch to
            // active timing never shows a clipped first enable run
            de_q <= is_active && win && (de_q || hnext == display_start);      // [R20]
        end
    end

    // ****************************************************************
    // Line, frame and AC bias pulses
    // ****************************************************************
    logic line_q;   // Line pin level
    logic frame_q;  // Frame pin level
    logic ac_q;     // AC bias level

    // Reset shows idle high, matching the reset polarity of 0
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            line_q  <= 1'b1;
            frame_q <= 1'b1;
            ac_q    <= 1'b0;
        end else if (tick_en) begin
            line_q <= line_pol ? line_act : !line_act;                // [R19]
            // Frame moves with line start, well clear of line edges
            if (hnext == 11'd0) begin
                frame_q <= frame_pol ? frm_act : !frm_act;            // [R05]
            end
            // Toggling at pixel 0 leads the line rise by its start
            if (!is_active && hnext == 11'd0 && vnext == 11'd0) begin
                ac_q <= !ac_q;                                        // [R09]
            end
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Unmapped reads answer zero; status shows the live line count
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rd_data_q <= 8'h00;
        end else if (clk_en_in) begin
            if (!rd_en_in) begin
                rd_data_q <= 8'h00;
            end else if (rd_slot[5]) begin
                rd_data_q <= regs_q[rd_slot[4:0]];
            end else if (addr_in == `LPT_OFF_STAT_LINE_LO) begin
                rd_data_q <= vcnt_q[7:0];
            end else if (addr_in == `LPT_OFF_STAT_LINE_HI) begin
                rd_data_q <= {de_q, frame_q, line_q, ac_q,
                              2'b00, vcnt_q[9:8]};
            end else begin
                rd_data_q <= 8'h00;
            end
        end
    end

    assign rd_data_out            = rd_data_q;
    assign panel_data_out         = data_q;
    assign line_pulse_out         = line_q;
    assign frame_pulse_out        = frame_q;
    assign shift_clock_out        = sc_q;
    assign second_shift_clock_out = sc2_q;
    assign display_enable_out     = de_q;
    assign ac_bias_out            = ac_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    a_hcnt_wrap: assert property (tick_en && hcnt_q == ht - 11'd1 |=>
        hcnt_q == 11'd0) else $error("line did not wrap"); // [R10]
    a_vcnt_wrap: assert property (tick_en && hwrap &&
        vcnt_q == vt - 11'd1 |=> vcnt_q == 11'd0)
        else $error("frame did not wrap"); // [R14]
    a_line_start: assert property (tick_en && hnext == line_start |=>
        line_q == line_pol) else $error("line pulse late"); // [R13]
    a_line_end: assert property (tick_en && {1'b0, hnext} ==
        {1'b0, line_start} + {1'b0, line_pulse_width} |=> line_q != line_pol)
        else $error("line pulse too wide"); // [R13]
    a_frame_hold: assert property (tick_en && hnext != 11'd0 &&
        $stable(frame_pol) |=> $stable(frame_q))
        else $error("frame moved mid line"); // [R05]
    a_de_open: assert property ($rose(de_q) |->
        $past(hnext) == display_start && $past(is_active))
        else $error("enable opened off start"); // [R20]
    a_shift_pair: assert property (!(sc_q && sc2_q))
        else $error("shift clocks overlap"); // [R01]
    a_shift_active: assert property (clk_en_in && tick && is_active |=>
        sc_q ##1 (sc_q || !clk_en_in))
        else $error("shift clock not following"); // [R22]
    a_ac_flip: assert property ($changed(ac_q) |->
        $past(hnext) == 11'd0 && $past(vnext) == 11'd0)
        else $error("bias flipped mid frame"); // [R09]

endmodule

`default_nettype wire

// >>> lpt_panel_model.sv
// Panel column driver model counting words latched per enabled run
`timescale 1ns/1ps
`default_nettype none
module lpt_panel_model (
    input  wire logic        clk_in,    // Core clock, samples the pins
    input  wire logic        shift_in,  // Shift clock pin
    input  wire logic        enable_in, // Display enable pin
    output logic      [15:0] words_out  // Words taken in last run
);
    logic        shift_q; // Shift level one cycle ago
    logic        en_q;    // Enable level one cycle ago
    logic [15:0] cnt_q;   // Words taken in the current run
    // ****
    // Column latch
    // ****
    // A word is taken on each shift fall while enable is high, as the
    // column drivers do; short runs show up as a low count
    always_ff @(posedge clk_in) begin
        shift_q <= shift_in;
        en_q    <= enable_in;
        if (enable_in && shift_q && !shift_in) begin
            cnt_q <= cnt_q + 16'h0001;
        end else if (!enable_in) begin
            cnt_q <= 16'h0000;
        end
        if (en_q && !enable_in) begin
            words_out <= cnt_q;
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the panel timing generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int PX = 8;      // Core cycles per pixel
    localparam int LN = 128*PX; // Line period in core cycles
    logic        clk   = 1'b0;  // Core clock
    logic        rst_n = 1'b0;  // Sync reset, low
    logic        pclk  = 1'b0;  // Pixel clock pin
    logic [7:0]  addr  = 8'h00; // Register address
    logic [7:0]  wdata = 8'h00; // Write data
    logic        wr    = 1'b0;  // Write strobe
    logic        rd    = 1'b0;  // Read strobe
    logic [17:0] pix   = 18'h00000; // Pixel word source
    wire         take;          // Pixel word consumed
    wire  [7:0]  rdata;         // Read data
    wire  [5:0]  pins;          // ac, de, sc2, sc, frame, line
    wire  [15:0] words;         // Words per enabled run
    int          error_cnt = 0; // Mismatches
    int          n_checks  = 0; // Comparisons
    int          hi, per, a, b, m; // Measurements
    // Width 64 keeps the software minimum of 16 pixels
    logic [15:0] cfg [17] = '{16'h120f, 16'h1407, 16'h1600, 16'h1700,
        16'h1804, 16'h1900, 16'h1c03, 16'h1d00, 16'h1e00, 16'h1f00,
        16'h2264, 16'h2300, 16'h2600, 16'h2700, 16'h1000, 16'h2000,
        16'h2400};
    // ****
    // Clocks, source and design
    // ****
    initial forever #12.5 clk = ~clk;
    // Pixel clock is eight core cycles, with its phase offset so its edges never meet a core clock edge
    initial begin
        #37;
        forever #100 pclk = ~pclk;
    end
    always @(posedge clk) if (take) pix <= pix + 18'h00001;
    lpt_timing_gen #(.DATA_W(18)) i_lpt_timing_gen (
        .core_clk_in(clk), .resetn_in(rst_n), .clk_en_in(1'b1),
        .pixel_clk_in(pclk), .addr_in(addr), .wr_data_in(wdata),
        .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata),
        .pixel_data_in(pix), .pixel_take_out(take), .panel_data_out(),
        .line_pulse_out(pins[0]), .frame_pulse_out(pins[1]),
        .shift_clock_out(pins[2]), .second_shift_clock_out(pins[3]),
        .display_enable_out(pins[4]), .ac_bias_out(pins[5]));
    lpt_panel_model i_lpt_panel_model (.clk_in(clk), .shift_in(pins[2]),
        .enable_in(pins[4]), .words_out(words));
    // ****
    // Shared tasks
    // ****
    task automatic conclude();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string s, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", s, exp, seen);
        end
    endtask
    // Strobes drop for one edge so no signal is set twice in a step
    task automatic wr_reg(input logic [7:0] a, d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // Bounded wait for a pin level, counting core cycles into n
    task automatic wait_lvl(input int k, input logic v, inout int n);
        while (pins[k] !== v) begin
            @(posedge clk);
            n++;
            if (n > 20000) begin
                error_cnt++;
                conclude();
            end
        end
    endtask
    task automatic meas(input int k, output int h, output int p);
        int n;
        n = 0;
        wait_lvl(k, 1'b0, n);
        wait_lvl(k, 1'b1, n);
        n = 0;
        wait_lvl(k, 1'b0, n);
        h = n;
        wait_lvl(k, 1'b1, n);
        p = n;
    endtask
    // Cycles from a rise of k0 to a rise of k1, then on to k2
    task automatic seq(input int k0, k1, k2, output int x, y);
        int n;
        n = 0;
        wait_lvl(k0, 1'b0, n);
        wait_lvl(k0, 1'b1, n);
        n = 0;
        wait_lvl(k1, 1'b1, n);
        x = n;
        n = 0;
        wait_lvl(k2, 1'b1, n);
        y = n;
    endtask
    task automatic setup(input logic [7:0] ptype, pol);
        for (int i = 0; i < 14; i++) wr_reg(cfg[i][15:8], cfg[i][7:0]);
        wr_reg(8'h20, pol | 8'h03);
        wr_reg(8'h24, pol | 8'h01);
        wr_reg(8'h10, ptype);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        logic [7:0] d;
        for (int i = 0; i < 17; i++) begin
            rd_reg(cfg[i][15:8], d);
            check("reg reset", d, 8'h00);
        end
        rd_reg(8'h30, d);
        check("unmapped read", d, 8'h00);
    endtask
    task automatic t_active();
        logic [7:0] d;
        setup(8'h01, 8'h80);
        for (int i = 0; i < 14; i++) begin
            rd_reg(cfg[i][15:8], d);
            check("reg readback", d, cfg[i][7:0]);
        end
        meas(0, hi, per);
        check("line width", hi, 4*PX);
        check("line period", per, LN);
        meas(1, hi, per);
        check("frame width", hi, 2*LN);
        check("frame period", per, 5*LN);
        seq(1, 0, 4, a, b);
        check("frame to line", a, 101*PX);
        check("line to enable", b, 32*PX);
        meas(4, hi, per);
        check("enable width", hi, 64*PX);
        check("words per run", words, 16'd64);
        meas(2, hi, per);
        check("pixel shift high", hi, PX/2);
        check("pixel shift period", per, PX);
    endtask
    task automatic t_passive();
        int hs[3] = '{2, 1, 2};
        int ps[3] = '{4, 2, 5};
        for (int f = 0; f < 3; f++) begin
            setup({2'b00, f[1:0], 4'h0}, 8'h00);
            m = 99999;
            for (int j = 0; j < 3; j++) begin
                meas(2, hi, per);
                if (per < m) m = per;
            end
            check("shift high", hi, hs[f]*PX);
            check("shift period", m, ps[f]*PX);
            if (f == 0) begin
                meas(3, hi, per);
                check("second shift high", hi, 2*PX);
            end else begin
                check("second shift idle", pins[3], 1'b0);
            end
        end
        meas(0, hi, per);
        check("low line width", per - hi, 4*PX);
        meas(5, hi, per);
        check("ac bias interval", hi, 5*LN);
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_active();
        t_passive();
        conclude();
    end
endmodule
`default_nettype wire
